// ==== i2ch_cfg.svh ====
// offsets, positions, timing constants for the two-wire host
`ifndef I2CH_CFG_SVH
`define I2CH_CFG_SVH
`define I2CH_OFS_COMMON_CONTROL_A 8'h00
`define I2CH_OFS_STATUS 8'h04
`define I2CH_OFS_BAUD 8'h08
`define I2CH_OFS_ADDR 8'h0C
`define I2CH_OFS_DATA 8'h10
`define I2CH_OFS_CTRLB 8'h14
`define I2CH_OFS_CLIENT 8'h18
`define I2CH_RESP_OKAY 2'h0
`define I2CH_RESP_SLVERR 2'h2
`define I2CH_BYTE 7:0
`define I2CH_HWORD 15:0
`define I2CH_CLK_NS 40
`define I2CH_TO_US 50
`define I2CH_TO_CYC (`I2CH_TO_US * 1000 / `I2CH_CLK_NS)
// low phase lasts baud+5 cycles: counter runs 0..baud+4
`define I2CH_LO_ADJ 9'h004
// high seen baud+5 cycles: two sync cycles plus 0..baud+2
`define I2CH_HI_ADJ 9'h002
`define I2CH_LO_TOTAL 10'h005
`define I2CH_WR_BITS 4'h8
`define I2CH_RD_BITS 4'h7
`define I2CH_RD_IDLE 9'h1FF
`define I2CH_RESET_BAUD 8'h00
`endif

// ==== i2ch_client_model.sv ====
// behavioural client on the shared two-wire bus
module i2ch_client_model
(
   // bus lines
   input wire logic scl,
   input wire logic sda,
   // data pull and last byte taken
   output logic sda_pull,
   output logic [7:0] last_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act = 1'b0;
   logic [3:0] bitn = 4'h0;
   logic [7:0] sh = 8'h00;
   initial
   begin
      sda_pull = 1'b0;
      last_byte = 8'h00;
   end
   // start and stop only count while clock high
   always @(negedge sda)
   begin
      // a clock fall in the same step is no start
      #1;
      if (scl)
      begin
         act = 1'b1;
         bitn = 4'h0;
      end
   end
   always @(posedge sda)
   begin
      // a clock fall in the same step is no stop
      #1;
      if (scl)
      begin
         act = 1'b0;
         sda_pull = 1'b0;
      end
   end
   // msb first, then one ack bit
   always @(posedge scl)
   begin
      if (act && bitn < 4'h8)
         sh = {sh[6:0], sda};
      if (act)
         bitn = bitn + 4'h1;
   end
   // only ever pulls low, never drives high
   always @(negedge scl)
   begin
      if (act && bitn == 4'h8)
         sda_pull = 1'b1;
      else if (act && bitn == 4'h9)
      begin
         sda_pull = 1'b0;
         last_byte = sh;
         bitn = 4'h0;
      end
   end
endmodule : i2ch_client_model

// ==== i2ch_host.sv ====
// two-wire host: bus state monitor, baud generator, byte engine, regs
`include "i2ch_cfg.svh"
module i2ch_host
   import i2ch_pkg::*;
#(
   parameter int TO_BASE_CYC = `I2CH_TO_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // open-drain bus lines
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   i2ch_state_s st;
   i2ch_state_s n;
   logic scl;
   logic sda;
   logic start_det;
   logic stop_det;
   logic to_hit;
   logic lost;
   logic berr_ev;
   logic force_idle;
   logic wr_fire;
   logic owned;
   logic [8:0] lo_lim;
   logic [8:0] hi_lim;
   logic [12:0] to_lim;
   logic [31:0] wd;
   i2ch_ctrlb_s cb;
   i2ch_status_s sr;
   logic [9:0] lowrun;

   always_comb
   begin
      n = st;
      n.scl_sy = {st.scl_sy[1:0], scl_i};
      n.sda_sy = {st.sda_sy[1:0], sda_i};
      scl = st.scl_sy[1];
      sda = st.sda_sy[1];
      start_det = scl & st.scl_sy[2] & st.sda_sy[2] & ~sda;
      stop_det = scl & st.scl_sy[2] & ~st.sda_sy[2] & sda;
      lo_lim = {1'b0, st.baud} + `I2CH_LO_ADJ;
      hi_lim = {1'b0, st.baud} + `I2CH_HI_ADJ;
      to_lim = 13'(TO_BASE_CYC) << (st.ctl.tosel - 2'h1);
      to_hit = (st.ctl.tosel != 2'h0) && (st.tocnt >= to_lim);
      // any line movement restarts the inactivity count
      if ((scl != st.scl_sy[2]) || (sda != st.sda_sy[2]))
         n.tocnt = 13'h0;
      else if (!to_hit)
         n.tocnt = st.tocnt + 13'h1;

      // register writes go first so hardware sets below win over clears
      force_idle = 1'b0;
      wd = st.wdat;
      cb = i2ch_ctrlb_s'(wd[`I2CH_BYTE]);
      sr = i2ch_status_s'(wd[`I2CH_BYTE]);
      wr_fire = st.aw_got && st.w_got && !st.bvalid;
      if (s_axi_awvalid && st.awready)
      begin
         n.aw_got = 1'b1;
         n.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready)
      begin
         n.w_got = 1'b1;
         n.wdat = s_axi_wdata;
         n.wstb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (wr_fire)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `I2CH_RESP_OKAY;
         case (st.awa)
         `I2CH_OFS_COMMON_CONTROL_A:
            if (st.wstb[0])
               n.ctl = i2ch_common_control_a_s'(wd[`I2CH_BYTE]);
         `I2CH_OFS_STATUS:
            if (st.wstb[0])
            begin
               // write one to clear; only Idle may be forced
               n.rif = st.rif & ~sr.rif;
               n.host_write_flag = st.host_write_flag & ~sr.host_write_flag;
               n.arbl = st.arbl & ~sr.arbl;
               n.berr = st.berr & ~sr.berr;
               force_idle = st.ctl.en && (sr.bus == BUS_IDLE);
            end
         `I2CH_OFS_BAUD:
            if (st.wstb[0])
               n.baud = wd[`I2CH_BYTE];
         `I2CH_OFS_ADDR:
            if (st.wstb[0])
            begin
               n.addr = wd[`I2CH_BYTE];
               n.rif = 1'b0;
               n.host_write_flag = 1'b0;
               n.arbl = 1'b0;
               n.berr = 1'b0;
               // repeated start from a held byte, else wait for Idle
               if (st.eng == E_HOLD)
               begin
                  n.eng = E_START;
                  n.ph = 1'b0;
                  n.cnt = 9'h0;
               end
               else
                  n.pend = 1'b1;
            end
         `I2CH_OFS_DATA:
            if (st.wstb[0] && st.eng == E_HOLD && !st.rd && st.host_write_flag)
            begin
               n.sh = {wd[`I2CH_BYTE], 1'b1};
               n.bits = `I2CH_WR_BITS;
               n.host_write_flag = 1'b0;
               n.addr_ph = 1'b0;
               n.eng = E_LOW;
               n.cnt = 9'h0;
            end
         `I2CH_OFS_CTRLB:
            if (st.wstb[0])
            begin
               n.ackact = cb.ackact;
               if (st.eng == E_HOLD && st.rd && st.rif &&
                   (cb.cmd == CMD_READ || cb.cmd == CMD_STOP))
               begin
                  // acknowledge bit goes out before the next step
                  n.sh = `I2CH_RD_IDLE;
                  n.sh[8] = cb.ackact;
                  n.bits = 4'h0;
                  n.ackonly = 1'b1;
                  n.stop_after = (cb.cmd == CMD_STOP);
                  n.rif = 1'b0;
                  n.eng = E_LOW;
                  n.cnt = 9'h0;
               end
               else if (st.eng == E_HOLD && cb.cmd == CMD_STOP)
               begin
                  n.rif = 1'b0;
                  n.host_write_flag = 1'b0;
                  n.eng = E_STOP;
                  n.ph = 1'b0;
                  n.cnt = 9'h0;
               end
            end
         `I2CH_OFS_CLIENT:
         begin
            // client setup is only stored
            if (st.wstb[0])
               n.cl.caddr = wd[6:0];
            if (st.wstb[1])
               n.cl = i2ch_client_s'(wd[`I2CH_HWORD]);
         end
         default:
            n.bresp = `I2CH_RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      if (st.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      if (s_axi_arvalid && st.arready)
      begin
         n.rvalid = 1'b1;
         n.rresp = `I2CH_RESP_OKAY;
         n.rdata = 32'h0;
         case (s_axi_araddr)
         `I2CH_OFS_COMMON_CONTROL_A:
            n.rdata[`I2CH_BYTE] = st.ctl;
         `I2CH_OFS_STATUS:
            n.rdata[`I2CH_BYTE] = {st.rif, st.host_write_flag, st.rif | st.host_write_flag,
               st.rxack, st.arbl, st.berr, st.bus};
         `I2CH_OFS_BAUD:
            n.rdata[`I2CH_BYTE] = st.baud;
         `I2CH_OFS_ADDR:
            n.rdata[`I2CH_BYTE] = st.addr;
         `I2CH_OFS_DATA:
            n.rdata[`I2CH_BYTE] = st.rx;
         `I2CH_OFS_CTRLB:
            n.rdata[`I2CH_BYTE] = {5'h0, st.ackact, CMD_NONE};
         `I2CH_OFS_CLIENT:
            n.rdata[`I2CH_HWORD] = st.cl;
         default:
            n.rresp = `I2CH_RESP_SLVERR;
         endcase
      end
      n.arready = !n.rvalid;

      // byte engine
      lost = 1'b0;
      berr_ev = (start_det | stop_det) &&
         (st.eng == E_LOW || st.eng == E_HIGH);
      owned = st.rd ? st.ackonly : (st.bits != 4'h0);
      case (st.eng)
      E_IDLE:
         if (st.pend && st.bus == BUS_IDLE)
         begin
            n.pend = 1'b0;
            n.own_start = 1'b1;
            n.eng = E_START;
            n.ph = 1'b0;
            n.cnt = 9'h0;
         end
      E_START:
         if (!st.ph)
         begin
            if (scl)
            begin
               n.cnt = st.cnt + 9'h1;
               if (st.cnt == hi_lim)
               begin
                  n.ph = 1'b1;
                  n.cnt = 9'h0;
               end
            end
         end
         else
         begin
            n.cnt = st.cnt + 9'h1;
            if (st.cnt == lo_lim)
            begin
               // address and direction bit
               n.sh = {st.addr, 1'b1};
               n.bits = `I2CH_WR_BITS;
               n.rd = 1'b0;
               n.ackonly = 1'b0;
               n.addr_ph = 1'b1;
               n.eng = E_LOW;
               n.cnt = 9'h0;
            end
         end
      E_LOW:
      begin
         n.cnt = st.cnt + 9'h1;
         if (st.cnt == lo_lim)
         begin
            n.eng = E_HIGH;
            n.cnt = 9'h0;
         end
      end
      E_HIGH:
         // released data bit read back low means another driver
         if (owned && st.sh[8] && scl && !sda)
            lost = 1'b1;
         else if (scl)
         begin
            // no high count until the line is really high
            n.cnt = st.cnt + 9'h1;
            if (st.cnt == hi_lim)
            begin
               n.cnt = 9'h0;
               n.eng = E_LOW;
               n.sh = {st.sh[7:0], sda};
               n.bits = st.bits - 4'h1;
               // nine bit packets on writes; a read byte ends after eight bits, its ack bit goes alone
               if (st.bits == 4'h0)
               begin
                  if (st.ackonly)
                  begin
                     n.ackonly = 1'b0;
                     n.sh = `I2CH_RD_IDLE;
                     n.bits = `I2CH_RD_BITS;
                     if (st.stop_after)
                     begin
                        n.eng = E_STOP;
                        n.ph = 1'b0;
                     end
                  end
                  else if (st.rd)
                  begin
                     n.rx = {st.sh[6:0], sda};
                     n.rif = 1'b1;
                     n.eng = E_HOLD;
                  end
                  else
                  begin
                     n.rxack = sda;
                     n.addr_ph = 1'b0;
                     if (st.addr_ph && !sda && st.addr[0])
                     begin
                        n.rd = 1'b1;
                        n.sh = `I2CH_RD_IDLE;
                        n.bits = `I2CH_RD_BITS;
                     end
                     else
                     begin
                        n.host_write_flag = 1'b1;
                        n.eng = E_HOLD;
                     end
                  end
               end
            end
         end
      E_HOLD:
         n.cnt = 9'h0;
      E_STOP:
         // data low under clock, then clock up, then data up
         if (!st.ph)
         begin
            n.cnt = st.cnt + 9'h1;
            if (st.cnt == lo_lim)
            begin
               n.ph = 1'b1;
               n.cnt = 9'h0;
            end
         end
         else if (scl)
         begin
            n.cnt = st.cnt + 9'h1;
            if (st.cnt == hi_lim)
               n.eng = E_IDLE;
         end
      default:
         n.eng = E_IDLE;
      endcase
      if (lost || berr_ev)
      begin
         n.eng = E_IDLE;
         n.host_write_flag = 1'b1;
         n.arbl = 1'b1;
         n.berr = st.berr | berr_ev;
         n.own_start = 1'b0;
      end

      // bus state monitor
      if (force_idle)
         n.bus = BUS_IDLE;
      else if ((lost || berr_ev) && st.bus == BUS_OWNER)
         n.bus = BUS_BUSY;
      else
         case (st.bus)
         BUS_UNKNOWN, BUS_BUSY:
            if (stop_det || to_hit)
               n.bus = BUS_IDLE;
         BUS_IDLE:
            if (start_det)
            begin
               n.bus = st.own_start ? BUS_OWNER : BUS_BUSY;
               n.own_start = 1'b0;
            end
         BUS_OWNER:
            if (stop_det)
               n.bus = BUS_IDLE;
         default:
            n.bus = BUS_UNKNOWN;
         endcase
      if (!n.ctl.en || !st.ctl.en)
      begin
         n.bus = BUS_UNKNOWN;
         n.eng = E_IDLE;
         n.pend = 1'b0;
         n.own_start = 1'b0;
      end

      // pins only ever pulled low
      n.scl_oe_n = !((n.eng == E_LOW) || (n.eng == E_STOP && !n.ph) ||
         (n.eng == E_HOLD && (n.rif || n.host_write_flag)));
      n.sda_oe_n = !(((n.eng == E_LOW || n.eng == E_HIGH) && !n.sh[8]) ||
         (n.eng == E_START && n.ph) || (n.eng == E_STOP));
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.baud <= `I2CH_RESET_BAUD;
         st.scl_oe_n <= 1'b1;
         st.sda_oe_n <= 1'b1;
      end
      else
         st <= n;
   end

   // helper for low-phase length checks
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         lowrun <= 10'h0;
      else if (st.eng == E_LOW)
         lowrun <= lowrun + 10'h1;
      else
         lowrun <= 10'h0;
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign scl_oe_n = st.scl_oe_n;
   assign sda_oe_n = st.sda_oe_n;
   // open-drain: the driven level is always low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   default clocking cb_core @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   property p_off_unknown;
      !st.ctl.en |=> st.bus == BUS_UNKNOWN;
   endproperty
   a_off_unknown: assert property (p_off_unknown)
      else $error("bus state not unknown while disabled");

   property p_force_idle;
      force_idle |=> st.bus == BUS_IDLE;
   endproperty
   a_force_idle: assert property (p_force_idle)
      else $error("forced idle ignored");

   property p_foreign_start;
      (st.ctl.en && !force_idle && st.bus == BUS_IDLE && start_det &&
         !st.own_start) |=> st.bus == BUS_BUSY;
   endproperty
   a_foreign_start: assert property (p_foreign_start)
      else $error("foreign start did not give busy");

   property p_own_start;
      (st.ctl.en && !force_idle && st.bus == BUS_IDLE && start_det &&
         st.own_start) |=> st.bus == BUS_OWNER;
   endproperty
   a_own_start: assert property (p_own_start)
      else $error("own start did not give owner");

   property p_low_len;
      (st.eng == E_HIGH && $past(st.eng) == E_LOW) |->
         lowrun == {2'h0, st.baud} + `I2CH_LO_TOTAL;
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("low phase length wrong");

   property p_high_wait;
      (st.eng == E_HIGH && st.cnt == 9'h0 && !scl) |=> st.cnt == 9'h0;
   endproperty
   a_high_wait: assert property (p_high_wait)
      else $error("high count began before line high");

   property p_hold;
      (st.eng == E_HOLD && (st.rif || st.host_write_flag)) |-> !scl_oe_n;
   endproperty
   a_hold: assert property (p_hold)
      else $error("clock not held while flag set");

   property p_lost;
      (lost && st.ctl.en && !force_idle && st.bus == BUS_OWNER) |=>
         (st.bus == BUS_BUSY && st.arbl && st.host_write_flag && scl_oe_n && sda_oe_n);
   endproperty
   a_lost: assert property (p_lost)
      else $error("arbitration loss handled wrongly");

   property p_timeout;
      (st.ctl.en && !force_idle && to_hit && st.bus == BUS_BUSY) |=>
         st.bus == BUS_IDLE;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("time-out did not give idle");

   sequence s_stop_tail;
      st.eng == E_STOP && st.ph && scl && st.cnt == hi_lim && st.ctl.en;
   endsequence
   property p_stop_end;
      s_stop_tail |=> (st.eng == E_IDLE && sda_oe_n) ##1 sda_oe_n;
   endproperty
   a_stop_end: assert property (p_stop_end)
      else $error("stop did not release data");
endmodule : i2ch_host

// ==== i2ch_pkg.sv ====
// types shared by the two-wire host
package i2ch_pkg;
   typedef enum logic [1:0] {
      BUS_UNKNOWN = 2'h0,
      BUS_IDLE = 2'h1,
      BUS_OWNER = 2'h2,
      BUS_BUSY = 2'h3
   } i2ch_bus_e;
   typedef enum logic [2:0] {
      E_IDLE = 3'h0,
      E_START = 3'h1,
      E_LOW = 3'h3,
      E_HIGH = 3'h2,
      E_HOLD = 3'h6,
      E_STOP = 3'h7
   } i2ch_eng_e;
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_RSV = 2'h1,
      CMD_READ = 2'h2,
      CMD_STOP = 2'h3
   } i2ch_cmd_e;
   typedef struct packed {
      logic rsv7;
      logic [1:0] hold_t;
      logic fmp;
      logic [1:0] tosel;
      logic rsv1;
      logic en;
   } i2ch_common_control_a_s;
   typedef struct packed {
      logic rif;
      logic host_write_flag;
      logic clkhold;
      logic rxack;
      logic arbl;
      logic berr;
      i2ch_bus_e bus;
   } i2ch_status_s;
   typedef struct packed {
      logic [4:0] rsv;
      logic ackact;
      i2ch_cmd_e cmd;
   } i2ch_ctrlb_s;
   typedef struct packed {
      logic [6:0] rsv;
      logic csetup;
      logic cen;
      logic [6:0] caddr;
   } i2ch_client_s;
   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      i2ch_common_control_a_s ctl;
      i2ch_client_s cl;
      logic [7:0] baud;
      logic rif;
      logic host_write_flag;
      logic rxack;
      logic arbl;
      logic berr;
      logic ackact;
      i2ch_bus_e bus;
      i2ch_eng_e eng;
      logic ph;
      logic [8:0] cnt;
      logic [12:0] tocnt;
      logic [8:0] sh;
      logic [3:0] bits;
      logic rd;
      logic ackonly;
      logic addr_ph;
      logic stop_after;
      logic pend;
      logic own_start;
      logic [7:0] addr;
      logic [7:0] rx;
      logic scl_oe_n;
      logic sda_oe_n;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] awa;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } i2ch_state_s;
endpackage : i2ch_pkg

// ==== tb_top.sv ====
// register-level bench for the two-wire host
`include "i2ch_cfg.svh"
module tb_top;
   import i2ch_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r, rr;
   logic [31:0] rdata, v;
   logic scl_oe_n, sda_oe_n, cl_pull, scl_drv, sda_drv;
   logic tb_sda_low = 1'b0;
   logic [7:0] cl_byte;
   logic prev = 1'b1;
   logic [9:0] lo_cnt = 10'h0, lo_len = 10'h0, per_cnt = 10'h0, per = 10'h0;
   int errors = 0;
   int checks = 0;
   // wired-AND with pull-up
   wire scl = scl_oe_n | scl_drv;
   wire sda = (sda_oe_n | sda_drv) & ~cl_pull & ~tb_sda_low;
   always #20 core_clk = ~core_clk;
   i2ch_host #(.TO_BASE_CYC(16)) DUT (.core_clk(core_clk),
      .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .scl_i(scl), .scl_o(scl_drv),
      .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_drv),
      .sda_oe_n(sda_oe_n));
   i2ch_client_model cl (.scl(scl), .sda(sda), .sda_pull(cl_pull),
      .last_byte(cl_byte));
   // low length and fall-to-fall period of the driven clock
   always @(posedge core_clk)
   begin
      prev <= scl_oe_n;
      lo_cnt <= scl_oe_n ? 10'h0 : lo_cnt + 10'h1;
      if (scl_oe_n && lo_cnt != 10'h0)
         lo_len <= lo_cnt;
      per_cnt <= (prev && !scl_oe_n) ? 10'h1 : per_cnt + 10'h1;
      if (prev && !scl_oe_n)
         per <= per_cnt;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ga, gw, gb;
      ga = 1'b0;
      gw = 1'b0;
      gb = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!gb)
      begin
         @(posedge core_clk);
         if (awvalid && awready === 1'b1)
         begin
            ga = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1)
         begin
            gw = 1'b1;
            wvalid <= 1'b0;
         end
         if (ga && gw && bvalid === 1'b1)
         begin
            gb = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic gr;
      gr = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!gr)
      begin
         @(posedge core_clk);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         if (!arvalid && rvalid === 1'b1)
         begin
            gr = 1'b1;
            v = rdata;
            rr = rresp;
            rready <= 1'b0;
         end
      end
   endtask : rd
   task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // poll for the write flag; gives up after 200 status reads
   task automatic wflag();
      repeat (200)
      begin
         rd(`I2CH_OFS_STATUS);
         if (v[6] === 1'b1)
            break;
      end
   endtask : wflag
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      #400000;
      errors++;
      end_of_test();
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("status", 32'h0, v);
      wr(`I2CH_OFS_CLIENT, 32'h0000_01A5);
      rd(`I2CH_OFS_CLIENT);
      chk("client", 32'h0000_01A5, v);
      wr(`I2CH_OFS_COMMON_CONTROL_A, 32'h0000_0030);
      wr(`I2CH_OFS_BAUD, 32'h0000_0008);
      wr(`I2CH_OFS_COMMON_CONTROL_A, 32'h0000_0031);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h0, v);
      wr(`I2CH_OFS_STATUS, 32'h0000_0002);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h0, v);
      wr(`I2CH_OFS_STATUS, 32'h0000_0001);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h1, v);
      $display("test init done");
      tb_sda_low <= 1'b1;
      repeat (5) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h3, v);
      tb_sda_low <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h1, v);
      $display("test foreign done");
      wr(`I2CH_OFS_ADDR, 32'h0000_00A4);
      wflag();
      chk("status", 32'h0000_0062, v);
      chk("scl_oe_n", 32'h0, {31'h0, scl_oe_n});
      chk("low", 32'hD, {22'h0, lo_len});
      chk("period", 32'h1A, {22'h0, per});
      chk("drive", 32'h0, {30'h0, scl_drv, sda_drv});
      chk("addr byte", 32'h0000_00A4, {24'h0, cl_byte});
      wr(`I2CH_OFS_DATA, 32'h0000_005A);
      wflag();
      chk("data byte", 32'h0000_005A, {24'h0, cl_byte});
      wr(`I2CH_OFS_CTRLB, 32'h0000_0003);
      repeat (60) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h1, v & 32'h3);
      chk("scl_oe_n", 32'h1, {31'h0, scl_oe_n});
      $display("test write done");
      wr(`I2CH_OFS_ADDR, 32'h0000_00FE);
      while (scl_oe_n !== 1'b0)
         @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      tb_sda_low <= 1'b1;
      wflag();
      chk("lost", 32'h0000_004B, v & 32'h4B);
      chk("lines", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
      tb_sda_low <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h1, v & 32'h3);
      $display("test arbitration done");
      wr(`I2CH_OFS_COMMON_CONTROL_A, 32'h0000_0035);
      tb_sda_low <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h3, v & 32'h3);
      repeat (40) @(posedge core_clk);
      rd(`I2CH_OFS_STATUS);
      chk("bus", 32'h1, v & 32'h3);
      wr(8'h1C, 32'h0);
      chk("bresp", 32'h2, {30'h0, r});
      rd(8'h1C);
      chk("rresp", 32'h2, {30'h0, rr});
      $display("test timeout done");
      end_of_test();
   end
endmodule : tb_top
